// ===== rtl/sabp_pkg.sv
// Purpose: shared constants and types of the capture register bank
// Assumes: byte addresses on a 7-bit serial address field
// Notes: counts and offsets live here only
package sabp_pkg;
    localparam logic [6:0] ADDR_AVG01 = 7'h06;
    localparam logic [6:0] ADDR_AVG23 = 7'h08;
    localparam logic [6:0] ADDR_PTR = 7'h0a;
    localparam logic [6:0] ADDR_REC = 7'h0c;
    localparam logic [6:0] ADDR_X = 7'h0e;
    localparam logic [6:0] ADDR_Y = 7'h10;
    localparam logic [6:0] ADDR_Z = 7'h12;
    localparam logic [15:0] AVG01_RST = 16'h0108;
    localparam logic [15:0] AVG23_RST = 16'h0101;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] REC_RST = 16'h0000;
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    localparam logic [1:0] MODE_TIME = 2'h2;
    localparam logic [1:0] MODE_STREAM = 2'h3;
    localparam logic [11:0] PTR_MAX_SPEC = 12'h7ff;
    localparam logic [11:0] PTR_MAX_TIME = 12'hfff;
    localparam logic [11:0] SAMPLE_LAST = 12'hfff;
    localparam logic [3:0] SPEC_REC_MAX = 4'h9;
    localparam logic [4:0] STAT_REC_MAX = 5'h1f;
    localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } sabp_frame_s;
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } sabp_axes_s;
endpackage

// ===== rtl/sabp_serial_port.sv
// Purpose: 16-bit serial frame slave, clock idles high, sampled on rise
// Assumes: serial clock well below a quarter of the system clock
// Notes: the answer word is preloaded while select is high
`timescale 1ns/10ps
module sabp_serial_port
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic [15:0] tx_word_in,
    output logic miso_out,
    output sabp_pkg::sabp_frame_s frame_out,
    output logic frame_valid_out
);
    import sabp_pkg::*;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            sclk_s <= 2'h3;
            cs_s <= 2'h3;
            mosi_s <= 2'h0;
            sclk_q <= 1'b1;
        end
        else
        begin
            sclk_s <= {sclk_s[0], sclk_in};
            cs_s <= {cs_s[0], cs_n_in};
            mosi_s <= {mosi_s[0], mosi_in};
            sclk_q <= sclk_s[1];
        end
    end

    assign rise = sclk_s[1] & ~sclk_q & ~cs_s[1];
    assign fall = ~sclk_s[1] & sclk_q & ~cs_s[1];

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            bit_cnt <= 4'h0;
            rx_sh <= 16'h0000;
        end
        else if (cs_s[1])
            bit_cnt <= 4'h0;
        else if (rise)
        begin
            rx_sh <= {rx_sh[14:0], mosi_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            frame_out <= '0;
            frame_valid_out <= 1'b0;
        end
        else
        begin
            frame_valid_out <= rise && bit_cnt == FRAME_LAST_BIT;
            if (rise && bit_cnt == FRAME_LAST_BIT)
                frame_out <= {rx_sh[14:0], mosi_s[1]};
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            tx_sh <= 16'h0000;
        else if (cs_s[1])
            tx_sh <= tx_word_in;
        else if (fall)
            tx_sh <= {tx_sh[14:0], 1'b0};
    end

    assign miso_out = tx_sh[15];

    chk_frame_count:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        frame_valid_out |-> $past(bit_cnt) == FRAME_LAST_BIT)
    else $error("frame ended before sixteen bits");
endmodule // sabp_serial_port

// ===== rtl/sabp_capture_regs.sv
// Purpose: averaging counts, capture sequencing, sample and record pointers
// Assumes: sample_in shows the user buffer word at buf_index_out
// Notes: sequencer handshakes come from logic on the same clock
`timescale 1ns/10ps

// Notes on behaviour
// - low averaging register: rate one high, zero low
// - low averaging register resets to eight and one
// - capture 4096, transform, accumulate until count reached
// - measure supply and temperature after every capture
// - more averages means longer record generation
// - high averaging register: rate three, two; ones
// - pointer clears at end of each capture
// - each axis output read advances pointer, except in streaming mode
// - pointer wraps to zero past its maximum
// - pointer maximum follows selected operating mode
// - pointer write loads all three axis outputs
// - spectral record 0..9 loads user buffers
// - statistics record 0..31 loads statistics buffers
// - stored modes advance only after whole word
// - mode codes: manual, automatic, time capture, streaming
module sabp_capture_regs
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    input wire logic [1:0] op_mode_in,
    input wire logic [1:0] rate_sel_in,
    input wire logic capture_start_in,
    input wire logic sample_valid_in,
    input wire logic fft_done_in,
    input wire logic avg_done_in,
    input wire sabp_pkg::sabp_axes_s sample_in,
    output logic [11:0] buf_index_out,
    output sabp_pkg::sabp_axes_s axes_out,
    output logic fft_start_out,
    output logic measure_out,
    output logic accum_out,
    output logic avg_start_out,
    output logic capture_done_out,
    output logic busy_out,
    output logic spectral_load_out,
    output logic [3:0] spectral_rec_out,
    output logic stat_load_out,
    output logic [4:0] stat_rec_out
);
    import sabp_pkg::*;
    typedef enum {S_IDLE, S_CAPTURE, S_FFT, S_AVERAGE, S_FINISH} sabp_state_e;

    sabp_state_e state;
    sabp_frame_s frame;
    logic frame_valid;
    logic [15:0] tx_word;
    logic [15:0] avg01;
    logic [15:0] avg23;
    logic [11:0] ptr;
    logic [15:0] rec_sel;
    logic [11:0] samp_cnt;
    logic [7:0] rec_cnt;
    logic [7:0] rec_target;
    logic fetch_pend;
    logic wr;
    logic rd;
    logic ptr_wr;
    logic ptr_inc;
    logic rd_axis;
    logic [11:0] next_ptr;
    logic [15:0] ptr_wr_word;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] put_byte(input logic [15:0] old,
        input logic [7:0] data, input logic hi);
        put_byte = hi ? {data, old[7:0]} : {old[15:8], data};
    endfunction

    function automatic logic [11:0] ptr_max(input logic [1:0] mode);
        ptr_max = (mode == MODE_TIME) ? PTR_MAX_TIME : PTR_MAX_SPEC;
    endfunction

    function automatic logic [7:0] count_for(input logic [1:0] rate,
        input logic [15:0] a01, input logic [15:0] a23);
        logic [7:0] c;
        c = 8'h00;
        case (rate)
            2'h0: c = a01[7:0];
            2'h1: c = a01[15:8];
            2'h2: c = a23[7:0];
            default: c = a23[15:8];
        endcase
        // zero is out of range; run it as a single record
        count_for = (c == 8'h00) ? 8'h01 : c;
    endfunction

    // ---------------------------------------------------------------
    // serial port and decode
    // ---------------------------------------------------------------
    sabp_serial_port u_port
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .tx_word_in(tx_word),
        .miso_out(miso_out),
        .frame_out(frame),
        .frame_valid_out(frame_valid)
    );

    assign wr = frame_valid & frame.wr;
    assign rd = frame_valid & ~frame.wr;
    assign ptr_wr = wr && {frame.addr[6:1], 1'b0} == ADDR_PTR;
    assign rd_axis = rd && ({frame.addr[6:1], 1'b0} == ADDR_X
        || {frame.addr[6:1], 1'b0} == ADDR_Y
        || {frame.addr[6:1], 1'b0} == ADDR_Z);
    // a word frame carries both bytes; streaming keeps the buffers idle
    assign ptr_inc = rd_axis && op_mode_in != MODE_STREAM;

    // ---------------------------------------------------------------
    // averaging counts
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            avg01 <= AVG01_RST;
            avg23 <= AVG23_RST;
        end
        else if (wr && {frame.addr[6:1], 1'b0} == ADDR_AVG01)
            avg01 <= put_byte(avg01, frame.data, frame.addr[0]);
        else if (wr && {frame.addr[6:1], 1'b0} == ADDR_AVG23)
            avg23 <= put_byte(avg23, frame.data, frame.addr[0]);
    end

    // ---------------------------------------------------------------
    // sample pointer
    // ---------------------------------------------------------------
    assign ptr_wr_word = put_byte({4'h0, ptr}, frame.data, frame.addr[0]);

    always_comb
    begin
        next_ptr = ptr;
        if (state == S_FINISH)
            next_ptr = 12'h000;
        else if (ptr_wr)
            // top nibble is dropped; a value past the mode limit folds
            next_ptr = ptr_wr_word[11:0] & ptr_max(op_mode_in);
        else if (ptr_inc)
            next_ptr = (ptr >= ptr_max(op_mode_in)) ? 12'h000
                : ptr + 12'h001;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            ptr <= PTR_RST[11:0];
        else
            ptr <= next_ptr;
    end

    assign buf_index_out = ptr;

    // new index is shown one cycle, then the three words are taken
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            fetch_pend <= 1'b0;
            axes_out <= '0;
        end
        else
        begin
            fetch_pend <= ptr_wr | ptr_inc | state == S_FINISH
                | spectral_load_out;
            if (fetch_pend)
                axes_out <= sample_in;
        end
    end

    // ---------------------------------------------------------------
    // record selector
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            rec_sel <= REC_RST;
            spectral_load_out <= 1'b0;
            stat_load_out <= 1'b0;
        end
        else
        begin
            spectral_load_out <= 1'b0;
            stat_load_out <= 1'b0;
            if (wr && {frame.addr[6:1], 1'b0} == ADDR_REC)
            begin
                rec_sel <= put_byte(rec_sel, frame.data, frame.addr[0]);
                if (!frame.addr[0] && frame.data[3:0] <= SPEC_REC_MAX)
                    spectral_load_out <= 1'b1;
                if (frame.addr[0] && frame.data[4:0] <= STAT_REC_MAX)
                    stat_load_out <= 1'b1;
            end
        end
    end

    assign spectral_rec_out = rec_sel[3:0];
    assign stat_rec_out = rec_sel[12:8];

    // ---------------------------------------------------------------
    // read answers, shifted out on the following frame
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            tx_word <= 16'h0000;
        else if (rd)
        begin
            case ({frame.addr[6:1], 1'b0})
                ADDR_AVG01: tx_word <= avg01;
                ADDR_AVG23: tx_word <= avg23;
                ADDR_PTR: tx_word <= {4'h0, ptr};
                ADDR_REC: tx_word <= rec_sel;
                ADDR_X: tx_word <= axes_out.x;
                ADDR_Y: tx_word <= axes_out.y;
                ADDR_Z: tx_word <= axes_out.z;
                default: tx_word <= 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // capture sequencer; each extra average adds a full pass
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            state <= S_IDLE;
            samp_cnt <= 12'h000;
            rec_cnt <= 8'h00;
            rec_target <= 8'h01;
            fft_start_out <= 1'b0;
            measure_out <= 1'b0;
            accum_out <= 1'b0;
            avg_start_out <= 1'b0;
        end
        else
        begin
            fft_start_out <= 1'b0;
            measure_out <= 1'b0;
            accum_out <= 1'b0;
            avg_start_out <= 1'b0;
            case (state)
                S_IDLE:
                    if (capture_start_in && op_mode_in != MODE_STREAM)
                    begin
                        state <= S_CAPTURE;
                        samp_cnt <= 12'h000;
                        rec_cnt <= 8'h00;
                        rec_target <= count_for(rate_sel_in, avg01,
                            avg23);
                    end
                S_CAPTURE:
                    if (sample_valid_in)
                    begin
                        samp_cnt <= samp_cnt + 12'h001;
                        if (samp_cnt == SAMPLE_LAST)
                        begin
                            measure_out <= 1'b1;
                            if (op_mode_in == MODE_TIME)
                                state <= S_FINISH;
                            else
                            begin
                                fft_start_out <= 1'b1;
                                state <= S_FFT;
                            end
                        end
                    end
                S_FFT:
                    if (fft_done_in)
                    begin
                        accum_out <= 1'b1;
                        rec_cnt <= rec_cnt + 8'h01;
                        samp_cnt <= 12'h000;
                        if (rec_cnt + 8'h01 == rec_target)
                        begin
                            avg_start_out <= 1'b1;
                            state <= S_AVERAGE;
                        end
                        else
                            state <= S_CAPTURE;
                    end
                S_AVERAGE:
                    if (avg_done_in)
                        state <= S_FINISH;
                S_FINISH:
                    state <= S_IDLE;
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    assign capture_done_out = state == S_FINISH;
    assign busy_out = state != S_IDLE;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    chk_ptr_clear:
    assert property (capture_done_out |=> ptr == 12'h000)
    else $error("pointer not cleared after capture");
    chk_ptr_advance:
    assert property (ptr_inc && !ptr_wr && !capture_done_out
        && ptr < ptr_max(op_mode_in) |=> ptr == $past(ptr) + 12'h001)
    else $error("pointer did not advance on axis read");
    chk_ptr_wrap:
    assert property (ptr_inc && !capture_done_out
        && ptr == ptr_max(op_mode_in) |=> ptr == 12'h000)
    else $error("pointer did not wrap");
    chk_ptr_range:
    assert property ($stable(op_mode_in) && $past(ptr) <= ptr_max(op_mode_in)
        |-> ptr <= ptr_max(op_mode_in))
    else $error("pointer beyond mode maximum");
    chk_stream_hold:
    assert property (op_mode_in == MODE_STREAM && !ptr_wr
        && !capture_done_out |=> $stable(ptr))
    else $error("pointer moved in streaming mode");
    chk_axes_load:
    assert property (ptr_wr |-> ##2 axes_out == $past(sample_in))
    else $error("axis outputs not loaded after pointer write");
    chk_spec_load:
    assert property (wr && frame.addr == ADDR_REC
        && frame.data[3:0] <= SPEC_REC_MAX |=> spectral_load_out
        && spectral_rec_out == $past(frame.data[3:0]))
    else $error("spectral record load missing");
    chk_stat_load:
    assert property (wr && frame.addr == (ADDR_REC | 7'h01)
        |=> stat_load_out && stat_rec_out == $past(frame.data[4:0]))
    else $error("statistics record load missing");
    chk_fft_after_capture:
    assert property (fft_start_out |-> $past(samp_cnt) == SAMPLE_LAST
        && measure_out && state == S_FFT)
    else $error("transform started before full capture");
    chk_avg_count:
    assert property (avg_start_out |-> rec_cnt == rec_target
        && $past(fft_done_in))
    else $error("averaging ended at wrong record count");
endmodule // sabp_capture_regs

// ===== testbench/sabp_host_model.sv
// Purpose: serial host for the capture register bank
// Assumes: clock idles high, device takes bits on rise, half period 5 clocks
// Notes: a read answer comes one frame late, so a dummy read fetches it
`timescale 1ns/10ps
module sabp_host_model
(
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    import sabp_pkg::*;
    initial
    begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // ----------------------------------------
    // frame engine
    // ----------------------------------------
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n_out <= 1'b0;
        repeat (5) @(posedge clk_in);
        for (int i = 15; i >= 0; i--)
        begin
            // device moves its line on every fall, the first one too,
            // so each answer bit is taken just before its fall
            r[i] = miso_in;
            sclk_out <= 1'b0;
            mosi_out <= w[i];
            repeat (5) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (5) @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        // released data line must not look like it still holds the bit
        mosi_out <= ~w[0];
        repeat (12) @(posedge clk_in);
    endtask
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] r;
        xfer({1'b1, a, v[7:0]}, r);
        xfer({1'b1, a | 7'h01, v[15:8]}, r);
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        logic [15:0] r;
        xfer({1'b0, a, 8'h00}, r);
        xfer({1'b0, ADDR_AVG01, 8'h00}, v);
    endtask
endmodule // sabp_host_model

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the capture register bank
// Assumes: user buffer word is a fixed function of the sample index
// Notes: transform and averaging engines answer two clocks after start
`timescale 1ns/10ps
module tb_top;
    import sabp_pkg::*;
    logic clk_sys_in, nrst_in, sclk, cs_n, mosi, miso;
    logic [1:0] op_mode, rate_sel;
    logic cap_start, smp_valid, fd1, ad1;
    logic fft_done = 1'b0;
    logic avg_done = 1'b0;
    sabp_axes_s sample, axes;
    logic [11:0] buf_index;
    logic fft_start, measure, accum, avg_start, cap_done, busy;
    logic spec_load, stat_load;
    logic [3:0] spec_rec;
    logic [4:0] stat_rec;
    int miscompares = 0;
    int checked = 0;
    int n_meas = 0, n_fft = 0, n_acc = 0, n_avg = 0, n_done = 0;
    int n_end = 0, n_busy = 0, n_spec = 0, n_stat = 0;
    int c1, c2, c3, c4;
    sabp_capture_regs dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
        .op_mode_in(op_mode), .rate_sel_in(rate_sel),
        .capture_start_in(cap_start), .sample_valid_in(smp_valid),
        .fft_done_in(fft_done), .avg_done_in(avg_done), .sample_in(sample),
        .buf_index_out(buf_index), .axes_out(axes), .fft_start_out(fft_start),
        .measure_out(measure), .accum_out(accum), .avg_start_out(avg_start),
        .capture_done_out(cap_done), .busy_out(busy),
        .spectral_load_out(spec_load), .spectral_rec_out(spec_rec),
        .stat_load_out(stat_load), .stat_rec_out(stat_rec));
    sabp_host_model host_u (.clk_in(clk_sys_in), .miso_in(miso),
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    function automatic sabp_axes_s smp(input logic [11:0] i);
        return {4'h1, i, 4'h2, i, 4'h3, i};
    endfunction
    assign sample = smp(buf_index);
    // ----------------------------------------
    // engine responder and pulse monitor
    // ----------------------------------------
    always @(posedge clk_sys_in)
    begin
        fd1 <= fft_start === 1'b1;
        fft_done <= fd1;
        ad1 <= avg_start === 1'b1;
        avg_done <= ad1;
        n_meas += (measure === 1'b1);
        n_fft += (fft_start === 1'b1);
        n_acc += (accum === 1'b1);
        n_avg += (avg_start === 1'b1);
        n_done += (cap_done === 1'b1);
        n_end += (accum === 1'b1) + (cap_done === 1'b1);
        n_busy += (busy === 1'b1);
        n_spec += (spec_load === 1'b1);
        n_stat += (stat_load === 1'b1);
    end
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t: word %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_axes(input sabp_axes_s got, exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t: axes %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_count(input int got, exp);
        checked++;
        if (got != exp)
        begin
            miscompares++;
            $display("Error %0t: count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic wait_ev(input bit dn, input int base);
        int k;
        for (k = 0; k < 60 && (dn ? n_done : n_end) <= base; k++)
            @(posedge clk_sys_in);
        if (k == 60)
        begin
            miscompares++;
            $display("Error %0t: engine wait ran out", $time);
            print_verdict();
        end
    endtask
    task automatic t_reset();
        logic [15:0] v;
        cmp_axes(axes, '0);
        host_u.rd16(ADDR_AVG01, v);
        cmp_word(v, 16'h0108);
        host_u.rd16(ADDR_AVG23, v);
        cmp_word(v, 16'h0101);
        host_u.rd16(ADDR_PTR, v);
        cmp_word(v, 16'h0000);
        host_u.rd16(ADDR_REC, v);
        cmp_word(v, 16'h0000);
        host_u.rd16(7'h20, v);
        cmp_word(v, 16'h0000);
        host_u.wr16(ADDR_AVG01, 16'h0102);
        host_u.rd16(ADDR_AVG01, v);
        cmp_word(v, 16'h0102);
        host_u.wr16(ADDR_AVG23, 16'h0201);
        host_u.rd16(ADDR_AVG23, v);
        cmp_word(v, 16'h0201);
    endtask
    task automatic t_ptr();
        logic [15:0] v;
        sabp_axes_s e;
        e = smp(12'h31c);
        host_u.wr16(ADDR_PTR, 16'h031c);
        cmp_word({4'h0, buf_index}, 16'h031c);
        cmp_axes(axes, e);
        host_u.rd16(ADDR_X, v);
        cmp_word(v, e.x);
        cmp_word({4'h0, buf_index}, 16'h031d);
        cmp_axes(axes, smp(12'h31d));
        op_mode <= MODE_STREAM;
        host_u.rd16(ADDR_Y, v);
        cmp_word({4'h0, buf_index}, 16'h031d);
    endtask
    task automatic t_wrap();
        logic [15:0] v;
        logic [11:0] mx;
        sabp_axes_s e;
        for (int m = 0; m < 3; m++)
        begin
            op_mode <= m[1:0];
            mx = (m == 2) ? 12'hfff : 12'h7ff;
            e = smp(mx);
            host_u.wr16(ADDR_PTR, 16'h0fff);
            cmp_word({4'h0, buf_index}, {4'h0, mx});
            host_u.rd16(ADDR_Z, v);
            cmp_word(v, e.z);
            cmp_word({4'h0, buf_index}, 16'h0000);
            cmp_axes(axes, smp(12'h000));
        end
    endtask
    task automatic t_rec();
        logic [15:0] v;
        int s0;
        int t0;
        s0 = n_spec;
        t0 = n_stat;
        host_u.xfer(16'h8c0a, v);
        cmp_count(n_spec - s0, 0);
        host_u.xfer(16'h8c05, v);
        cmp_count(n_spec - s0, 1);
        cmp_word({12'h000, spec_rec}, 16'h0005);
        host_u.xfer(16'h8d0c, v);
        cmp_count(n_stat - t0, 1);
        cmp_word({11'h000, stat_rec}, 16'h000c);
        host_u.rd16(ADDR_REC, v);
        cmp_word(v, 16'h0c05);
    endtask
    task automatic run_cap(input logic [1:0] md, rs, input int recs,
        output int cyc);
        int m0, f0, a0, g0, d0, b0, e0, nf;
        host_u.wr16(ADDR_PTR, 16'h0123);
        m0 = n_meas;
        f0 = n_fft;
        a0 = n_acc;
        g0 = n_avg;
        d0 = n_done;
        b0 = n_busy;
        nf = (md == MODE_TIME) ? 0 : recs;
        op_mode <= md;
        rate_sel <= rs;
        cap_start <= 1'b1;
        @(posedge clk_sys_in);
        cap_start <= 1'b0;
        for (int r = 0; r < recs; r++)
        begin
            e0 = n_end;
            repeat (4096)
            begin
                smp_valid <= 1'b1;
                @(posedge clk_sys_in);
                smp_valid <= 1'b0;
                @(posedge clk_sys_in);
            end
            wait_ev(1'b0, e0);
        end
        wait_ev(1'b1, d0);
        repeat (3) @(posedge clk_sys_in);
        cmp_count(n_meas - m0, recs);
        cmp_count(n_fft - f0, nf);
        cmp_count(n_acc - a0, nf);
        cmp_count(n_avg - g0, (nf > 0) ? 1 : 0);
        cmp_count(n_done - d0, 1);
        cmp_word({4'h0, buf_index}, 16'h0000);
        cmp_axes(axes, smp(12'h000));
        cyc = n_busy - b0;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        nrst_in = 1'b0;
        op_mode = MODE_MANUAL;
        rate_sel = 2'h0;
        cap_start = 1'b0;
        smp_valid = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_reset();
        t_ptr();
        t_wrap();
        t_rec();
        run_cap(MODE_MANUAL, 2'h0, 2, c2);
        run_cap(MODE_AUTO, 2'h1, 1, c1);
        run_cap(MODE_MANUAL, 2'h3, 2, c3);
        run_cap(MODE_TIME, 2'h0, 1, c4);
        cmp_count(c2 > c1, 1);
        print_verdict();
    end
endmodule // tb_top
